// ==== rtl/ddmfc_defines.svh ====
`ifndef DDMFC_DEFINES_SVH
`define DDMFC_DEFINES_SVH

`define DDMFC_BA_MODE_ZERO 3'h0
`define DDMFC_BA_MODE_ONE 3'h1
`define DDMFC_BA_MODE_TWO 3'h2
`define DDMFC_BA_MODE_THREE 3'h3
`define DDMFC_MR0_DLL_RESET_BIT 8
`define DDMFC_MR1_DLL_OFF_BIT 0
`define DDMFC_MR1_LEVEL_BIT 7
`define DDMFC_MR1_NOM_BIT0 2
`define DDMFC_MR1_NOM_BIT1 6
`define DDMFC_MR1_NOM_BIT2 9
`define DDMFC_MR2_CWL_LSB 3
`define DDMFC_MR2_WRT_LSB 9
`define DDMFC_MR3_PATTERN_BIT 2
`define DDMFC_MR0_CL_RESET 4'h4
`define DDMFC_MR2_CWL_RESET 3'h1
`define DDMFC_DLL_OFF_CL 4'h6
`define DDMFC_DLL_OFF_CWL 4'h6
`define DDMFC_PATTERN_WORD 8'h55

`endif

// ==== rtl/ddmfc_pkg.sv ====
package ddmfc_pkg;
	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [2:0] bank;
		logic [13:0] addr;
	} ddmfc_cmd_s;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_MODE_SET,
		CMD_READ,
		CMD_WRITE,
		CMD_OTHER
	} ddmfc_kind_e;

	typedef struct packed {
		logic dllOff;
		logic patternOn;
		logic [1:0] patternSel;
		logic [1:0] dynTerm;
		logic levelOn;
		logic [2:0] nomTerm;
	} ddmfc_mode_s;
endpackage : ddmfc_pkg

// ==== rtl/ddmfc_core.sv ====
`timescale 1ns/10ps
`include "ddmfc_defines.svh"
// How it works
// RULE1 - Dynamic termination from mode two bits nine, ten
// RULE2 - All strobes low, bank three loads mode three
// RULE3 - Controller zeroes reserved mode three bits
// RULE4 - Pattern select ignored while pattern readout off
// RULE5 - Controller enables readout only with banks idle
// RULE6 - Reads return calibration pattern while readout on
// RULE7 - Controller issues only reads during readout
// RULE8 - No-operation registers nothing, work continues
// RULE9 - Deselect executes nothing, work continues
// RULE10 - Mode one bit zero turns delay loop off
// RULE11 - Delay-loop-off mode supports latencies six only
// RULE12 - Loop-off read strobe one cycle earlier
// RULE13 - Controller follows loop-off switching steps
// RULE14 - Controller holds CKE high after exit
// RULE15 - Controller waits exit time, then reprograms
// RULE16 - Controller follows loop-on switching steps
// RULE17 - Controller holds CKE high until relock
// RULE18 - Clock changes only in self-refresh or power-down
// RULE19 - Clock is don't-care after entry time
// RULE20 - Power-down frequency change keeps ODT, CKE low
// RULE21 - After power-down change, reset loop by mode set
// RULE22 - Controller keeps frequency within speed grade
// RULE23 - Controller disables dynamic termination when loop off
// RULE24 - Controller disables nominal termination when loop off
// RULE25 - Controller counts each timing in cycles
module ddmfc_core
	import ddmfc_pkg::*;
#(
	parameter int LAT_W = 5
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cke,
	input wire ddmfc_cmd_s cmdIn,
	input wire logic [7:0] arrayData,
	output ddmfc_mode_s modeState,
	output logic [3:0] casLatency,
	output logic [3:0] casWriteLatency,
	output logic latencyFault,
	output logic dllResetPulse,
	output logic readFromPattern,
	output logic readIssued,
	output logic [7:0] readData,
	output logic strobeStart,
	output logic [2:0] dynTermActive
);
	logic rstMeta;
	logic rstSync;
	ddmfc_mode_s mode_reg;
	ddmfc_mode_s mode_next;
	logic [3:0] cl_reg;
	logic [3:0] cwl_reg;
	logic [LAT_W-1:0] strobeCnt_reg;
	logic [LAT_W-1:0] strobeCnt_next;

	function automatic ddmfc_kind_e decodeCmd(input ddmfc_cmd_s c);
		if (c.csN)
			return CMD_NONE;
		case ({c.rasN, c.casN, c.weN})
			3'h7: return CMD_NONE;
			3'h0: return CMD_MODE_SET;
			3'h5: return CMD_READ;
			3'h4: return CMD_WRITE;
			default: return CMD_OTHER;
		endcase
	endfunction : decodeCmd

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// Deselect and no-operation both decode to CMD_NONE, so nothing is taken. [RULE8] [RULE9]
	ddmfc_kind_e kind;
	assign kind = cke ? decodeCmd(cmdIn) : CMD_NONE; // [RULE19]
	wire isModeSet = (kind == CMD_MODE_SET);
	wire isRead = (kind == CMD_READ);
	wire setZero = isModeSet && (cmdIn.bank == `DDMFC_BA_MODE_ZERO);
	wire setOne = isModeSet && (cmdIn.bank == `DDMFC_BA_MODE_ONE);
	wire setTwo = isModeSet && (cmdIn.bank == `DDMFC_BA_MODE_TWO);
	wire setThree = isModeSet && (cmdIn.bank == `DDMFC_BA_MODE_THREE); // [RULE2]
	wire patternBit = cmdIn.addr[`DDMFC_MR3_PATTERN_BIT];
	wire [3:0] clField = {cmdIn.addr[2], cmdIn.addr[6:4]};
	wire [3:0] cwlField = {1'b0, cmdIn.addr[`DDMFC_MR2_CWL_LSB +: 3]};
	// Latency fields are stored offset, so the CL field plus four and the CWL field plus five give cycles.
	wire [3:0] clCycles = 4'(clField + 4'h4);
	wire [3:0] cwlCycles = 4'(cwlField + 4'h5);

	always_comb
	begin
		mode_next = mode_reg;
		if (setOne)
		begin
			mode_next.dllOff = cmdIn.addr[`DDMFC_MR1_DLL_OFF_BIT]; // [RULE10]
			mode_next.levelOn = cmdIn.addr[`DDMFC_MR1_LEVEL_BIT];
			mode_next.nomTerm = {cmdIn.addr[`DDMFC_MR1_NOM_BIT2],
				cmdIn.addr[`DDMFC_MR1_NOM_BIT1], cmdIn.addr[`DDMFC_MR1_NOM_BIT0]};
		end
		if (setTwo)
			mode_next.dynTerm = cmdIn.addr[`DDMFC_MR2_WRT_LSB +: 2]; // [RULE1]
		if (setThree)
		begin
			mode_next.patternOn = patternBit;
			// Select bits only count while readout is being enabled. [RULE4]
			mode_next.patternSel = patternBit ? cmdIn.addr[1:0] : 2'h0;
		end
	end

	always_ff @(posedge mclk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			mode_reg <= '0;
			cl_reg <= `DDMFC_MR0_CL_RESET;
			cwl_reg <= 4'(`DDMFC_MR2_CWL_RESET + 4'h5);
		end
		else
		begin
			mode_reg <= mode_next;
			if (setZero)
				cl_reg <= clCycles;
			if (setTwo)
				cwl_reg <= cwlCycles;
		end
	end

	// Read strobe lead: loop off references one cycle earlier. [RULE12]
	wire [LAT_W-1:0] readDelay = mode_reg.dllOff ? LAT_W'(cl_reg - 4'h1) : LAT_W'(cl_reg);
	always_comb
	begin
		strobeCnt_next = strobeCnt_reg;
		if (isRead)
			strobeCnt_next = readDelay;
		else if (strobeCnt_reg != '0)
			strobeCnt_next = LAT_W'(strobeCnt_reg - 1'b1);
	end

	always_ff @(posedge mclk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			strobeCnt_reg <= '0;
			modeState <= '0;
			casLatency <= `DDMFC_MR0_CL_RESET;
			casWriteLatency <= 4'(`DDMFC_MR2_CWL_RESET + 4'h5);
			latencyFault <= 1'b0;
			dllResetPulse <= 1'b0;
			readFromPattern <= 1'b0;
			readIssued <= 1'b0;
			readData <= 8'h00;
			strobeStart <= 1'b0;
			dynTermActive <= 3'h0;
		end
		else
		begin
			strobeCnt_reg <= strobeCnt_next;
			modeState <= mode_next;
			casLatency <= setZero ? clCycles : cl_reg;
			casWriteLatency <= setTwo ? cwlCycles : cwl_reg;
			// Loop-off mode only supports the six/six latency pair. [RULE11]
			latencyFault <= mode_reg.dllOff && ((cl_reg != `DDMFC_DLL_OFF_CL)
				|| (cwl_reg != `DDMFC_DLL_OFF_CWL));
			dllResetPulse <= setZero && cmdIn.addr[`DDMFC_MR0_DLL_RESET_BIT];
			readIssued <= isRead;
			readFromPattern <= isRead && mode_reg.patternOn; // [RULE6]
			if (isRead)
				readData <= mode_reg.patternOn ? `DDMFC_PATTERN_WORD : arrayData; // [RULE6]
			// The pulse stands at the reference edge itself, so it is launched one edge early.
			strobeStart <= (strobeCnt_next == LAT_W'(1)); // [RULE12]
			// Leveling leaves only nominal termination available. [RULE1]
			dynTermActive <= mode_reg.levelOn ? 3'h0 : {1'b0, mode_reg.dynTerm};
		end
	end
endmodule : ddmfc_core

// ==== bench/ddmfc_checker.sv ====
`timescale 1ns/10ps
module ddmfc_checker
	import ddmfc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cke,
	input wire ddmfc_cmd_s cmdIn,
	input wire ddmfc_mode_s modeState,
	input wire logic [7:0] readData,
	input wire logic strobeStart
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic go = cke && !cmdIn.csN;
	wire logic [3:0] k = {go, cmdIn.rasN, cmdIn.casN, cmdIn.weN};
	wire logic [6:0] m = {k, cmdIn.bank};
	wire logic [13:0] a = cmdIn.addr;
	property p_m3; m == 7'h43 |=> modeState.patternOn == $past(a[2]); endproperty
	a_m3: assert property (p_m3) else $error("m3");
	property p_sel; m == 7'h43 && !a[2] |=> modeState.patternSel == 2'h0; endproperty
	a_sel: assert property (p_sel) else $error("sel");
	property p_pat; k == 4'hD && modeState.patternOn |=> readData == 8'h55; endproperty
	a_pat: assert property (p_pat) else $error("pat");
	property p_nop; k == 4'hF |=> $stable(modeState); endproperty
	a_nop: assert property (p_nop) else $error("nop");
	property p_dsl; !go |=> $stable(modeState); endproperty
	a_dsl: assert property (p_dsl) else $error("dsl");
	property p_m1; m == 7'h41 |=> modeState.dllOff == $past(a[0]); endproperty
	a_m1: assert property (p_m1) else $error("m1");
	property p_m2; m == 7'h42 |=> modeState.dynTerm == $past(a[10:9]); endproperty
	a_m2: assert property (p_m2) else $error("m2");
	property p_off; k == 4'hD && modeState.dllOff |-> ##5 strobeStart; endproperty
	a_off: assert property (p_off) else $error("off");
	cover property (k == 4'hD && modeState.patternOn);
	cover property (k == 4'hD && modeState.dllOff);
	cover property (k == 4'hF);
endmodule : ddmfc_checker
bind ddmfc_core ddmfc_checker chk_u (.mclk, .rst_n, .cke, .cmdIn, .modeState, .readData,
	.strobeStart);

// ==== bench/ddmfc_ctrl_model.sv ====
`timescale 1ns/10ps
module ddmfc_ctrl_model
	import ddmfc_pkg::*;
(
	input wire logic mclk,
	output ddmfc_cmd_s cmd
);
	initial cmd = {4'hF, 17'h00000};
	task automatic issue(input logic [2:0] op, input logic [2:0] bk, input logic [13:0] ad);
		cmd <= {1'b0, op, bk, ad};
		@(negedge mclk);
	endtask : issue
	// A deselected bus carries the inverse of its last value.
	task automatic idle();
		cmd <= {1'b1, ~cmd[19:0]};
		@(negedge mclk);
	endtask : idle
endmodule : ddmfc_ctrl_model

// ==== bench/dram_dll_mode_freq_change_tb_top.sv ====
`timescale 1ns/10ps
module dram_dll_mode_freq_change_tb_top
	import ddmfc_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, cke = 1'b0;
	logic [7:0] arrayData = 8'h00, readData;
	ddmfc_cmd_s cmdIn;
	ddmfc_mode_s modeState;
	int err_total = 0, n_checks = 0, po = 0;
	always #10 mclk = ~mclk;
	logic [3:0] casLatency, casWriteLatency;
	logic latencyFault, dllResetPulse, readFromPattern, readIssued, strobeStart;
	logic [2:0] dynTermActive;
	ddmfc_core dut_u (.mclk, .rst_n, .cke, .cmdIn, .arrayData, .modeState, .casLatency,
		.casWriteLatency, .latencyFault, .dllResetPulse, .readFromPattern,
		.readIssued, .readData, .strobeStart, .dynTermActive);
	ddmfc_ctrl_model pm (.mclk, .cmd(cmdIn));
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL %0t %h %h", $time, g, e);
		end
	endtask : ck
	task automatic conclude();
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic rd();
		logic [7:0] v;
		v = 8'($urandom);
		arrayData <= v;
		pm.issue(3'h5, 3'h0, 14'h0000);
		ck(readData, (po != 0) ? 8'h55 : v);
		ck({7'h00, readIssued}, 8'h01);
		ck({7'h00, readFromPattern}, 8'(po));
	endtask : rd
	initial
	begin
		void'($urandom(22965));
		repeat (4) @(negedge mclk);
		rst_n <= 1'b1;
		cke <= 1'b1;
		repeat (3) @(negedge mclk);
		pm.issue(3'h0, 3'h3, 14'h0003);
		pm.issue(3'h7, 3'h3, 14'h0004);
		ck({6'h00, modeState.patternSel}, 8'h00);
		rd();
		pm.issue(3'h0, 3'h3, 14'h0006);
		po = 1;
		rd();
		rd();
		pm.issue(3'h0, 3'h3, 14'h0000);
		po = 0;
		rd();
		pm.issue(3'h0, 3'h2, 14'h0600);
		pm.issue(3'h0, 3'h0, 14'h0020);
		ck({4'h0, casLatency}, 8'h06);
		ck({5'h00, dynTermActive}, 8'h03);
		pm.issue(3'h0, 3'h2, 14'h0008);
		ck({4'h0, casWriteLatency}, 8'h06);
		pm.issue(3'h0, 3'h1, 14'h0001);
		rd();
		repeat (3) pm.idle();
		ck({7'h00, strobeStart}, 8'h00);
		pm.idle();
		ck({7'h00, strobeStart}, 8'h01);
		ck({7'h00, latencyFault}, 8'h00);
		cke <= 1'b0;
		pm.issue(3'h0, 3'h1, 14'h0000);
		cke <= 1'b1;
		repeat (5) pm.idle();
		ck({7'h00, modeState.dllOff}, 8'h01);
		cke <= 1'b0;
		repeat (8) pm.idle();
		cke <= 1'b1;
		repeat (4) pm.idle();
		pm.issue(3'h0, 3'h1, 14'h0000);
		ck({7'h00, modeState.dllOff}, 8'h00);
		pm.issue(3'h0, 3'h0, 14'h0120);
		ck({7'h00, dllResetPulse}, 8'h01);
		pm.idle();
		ck({7'h00, dllResetPulse}, 8'h00);
		rd();
		repeat (4) pm.idle();
		ck({7'h00, strobeStart}, 8'h00);
		pm.idle();
		ck({7'h00, strobeStart}, 8'h01);
		conclude();
	end
endmodule : dram_dll_mode_freq_change_tb_top
